/* File: hw/cacjc_defines.svh */
// Summary of operation
// - after reset every diagnostic, fault and interrupt enable is off.
// - one enable per condition, response type and channel; any mix allowed.
// - enabled diagnostic sets its bit while the alarm is present.
// - enabled fault reporting posts one log entry per alarm occurrence.
// - enabled interrupt raises a request on each alarm occurrence.
// - disabled diagnostic with no interrupt never sets its bit.
// - an interrupt on a diag-disabled condition still sets that bit.
// - the next host input scan clears such an interrupt-set bit.
// - interrupt names the channel base word, two words per channel.
// - cold-junction value reported as 16-bit integer or 32-bit float.
// - user offset added to cold-junction values, limited to 25 C or 45 F.
// - cold-junction inputs have under, over, open enables per response.
// - four scan settings: none, both, first only, second only.
// - no sensor scanned means a fixed 25 C terminal temperature.
// - first-only skips second sensor conversion.
// - second-only skips first sensor conversion.
// - both scanned: difference is first minus second temperature.
// - difference scaled by fixed per-channel multiplier.
// - terminal temperature turned into per-type thermoelectric correction.
// - diagnostic bit reads 1 while an enabled condition is present or while an interrupt-set bit is held, else 0.
// - integer format fills the upper word with the sign.
`ifndef CACJC_DEFINES_SVH
`define CACJC_DEFINES_SVH

// register byte offsets
`define CACJC_OFS_ENA      12'h000
`define CACJC_OFS_CFG      12'h028
`define CACJC_OFS_TCTYPE   12'h02C
`define CACJC_OFS_TBTEMP   12'h030
`define CACJC_OFS_CJCVAL   12'h050
`define CACJC_OFS_DIAG     12'h058
`define CACJC_OFS_TCCORR   12'h080
`define CACJC_OFS_END      12'h0A0

// enable register fields
`define CACJC_ENA_DIAG_LSB 0
`define CACJC_ENA_FLT_LSB  10
`define CACJC_ENA_IRQ_LSB  20
// cfg register fields
`define CACJC_CFG_SCAN_LSB 0
`define CACJC_CFG_FMT_BIT  2
`define CACJC_CFG_UNIT_BIT 3
`define CACJC_CFG_OFS_LSB  16

// reset values
`define CACJC_RST_ENA      10'h000
`define CACJC_RST_OFFSET   16'h0000
`define CACJC_RST_TCTYPE   3'h0

// conditions allowed on cold-junction inputs: under, over, open wire
`define CACJC_CJC_COND_MASK 10'h01C

// temperatures in 1/16 degree
`define CACJC_REF_C        16'h0190
`define CACJC_REF_F        16'h04D0
`define CACJC_LIM_C        16'h0190
`define CACJC_LIM_F        16'h02D0

// per-channel multipliers in hundredths
`define CACJC_MUL_CH1      8'h0A
`define CACJC_MUL_CH2      8'h05
`define CACJC_MUL_CH3      8'h19
`define CACJC_MUL_CH4      8'h19
`define CACJC_MUL_CH5      8'h2D
`define CACJC_MUL_CH6      8'h3C
`define CACJC_MUL_CH7      8'h4B
`define CACJC_MUL_CH8      8'h5A
`define CACJC_MUL_DIV      24'sh000064

// thermoelectric slopes per type, uV per degree (plain defaults)
`define CACJC_SEEB_J       9'h034
`define CACJC_SEEB_K       9'h029
`define CACJC_SEEB_T       9'h02B
`define CACJC_SEEB_E       9'h03D
`define CACJC_SEEB_N       9'h01B
`define CACJC_SEEB_R       9'h006
`define CACJC_SEEB_S       9'h006
`define CACJC_SEEB_B       9'h001

`endif

/* File: hw/cacjc_pkg.sv */
package cacjc_pkg;
  typedef enum logic [1:0] {
    CACJC_SCAN_NONE  = 2'b00,
    CACJC_SCAN_BOTH  = 2'b01,
    CACJC_SCAN_FIRST = 2'b10,
    CACJC_SCAN_SECND = 2'b11
  } cacjc_scan_t;

  typedef enum logic [2:0] {
    CACJC_TC_J = 3'b000,
    CACJC_TC_K = 3'b001,
    CACJC_TC_T = 3'b010,
    CACJC_TC_E = 3'b011,
    CACJC_TC_N = 3'b100,
    CACJC_TC_R = 3'b101,
    CACJC_TC_S = 3'b110,
    CACJC_TC_B = 3'b111
  } cacjc_tc_t;

  typedef logic signed [15:0] cacjc_temp_t;
endpackage

/* File: hw/cacjc_i2f.sv */
`timescale 1ns/1ps
module cacjc_i2f import cacjc_pkg::*; #(
  parameter int FRAC = 4
) (
  input  wire logic signed [15:0] i_val,  // fixed point value
  output logic             [31:0] o_flt   // single precision float
);
  logic [16:0] mag;
  logic [4:0]  pos;
  logic [39:0] sh;
  logic [7:0]  expo;

  always_comb begin
    mag = i_val[15] ? 17'(-{i_val[15], i_val}) : {1'b0, i_val};
    pos = 5'h00;
    for (int b = 0; b < 17; b++) begin
      if (mag[b]) begin
        pos = 5'(b);
      end
    end
    sh   = {23'h000000, mag} << (5'd23 - pos);
    expo = 8'(8'd127 + {3'b000, pos} - 8'(FRAC));
    if (mag == 17'h00000) begin
      o_flt = 32'h00000000;
    end else begin
      o_flt = {i_val[15], expo, sh[22:0]};
    end
  end
endmodule

/* File: hw/cacjc_top.sv */
`timescale 1ns/1ps
`include "cacjc_defines.svh"
module cacjc_top import cacjc_pkg::*; #(
  parameter int N_CH   = 8,   // thermocouple channels
  parameter int N_CJC  = 2,   // cold-junction inputs
  parameter int N_COND = 10,  // alarm conditions per channel
  parameter int FRAC   = 4    // fraction bits of temperatures
) (
  input  wire logic                 i_core_clk,    // 200 MHz clock
  input  wire logic                 i_rst_b,       // async reset, low
  input  wire logic                 i_psel,        // apb select
  input  wire logic                 i_penable,     // apb enable
  input  wire logic                 i_pwrite,      // apb direction
  input  wire logic [11:0]          i_paddr,       // apb byte address
  input  wire logic [31:0]          i_pwdata,      // apb write data
  output logic                      o_pready,      // apb ready
  output logic      [31:0]          o_prdata,      // apb read data
  output logic                      o_pslverr,     // apb error
  input  wire logic [N_CH+N_CJC-1:0][N_COND-1:0]
                                    i_alarm,       // alarm levels
  input  wire logic                 i_host_scan,   // host scan pulse
  input  wire logic [N_CJC-1:0][15:0]
                                    i_cjc_temp,    // sensor temps
  output logic      [N_CJC-1:0]     o_cjc_conv,    // convert sensor
  output logic [N_CH+N_CJC-1:0][N_COND-1:0]
                                    o_diag,        // diagnostic bits
  output logic                      o_flt_valid,   // fault entry valid
  output logic      [3:0]           o_flt_ch,      // fault channel
  output logic      [3:0]           o_flt_cond,    // fault condition
  input  wire logic                 i_flt_ready,   // fault entry taken
  output logic                      o_irq_valid,   // interrupt request
  output logic      [4:0]           o_irq_word,    // channel base word
  input  wire logic                 i_irq_ready,   // interrupt taken
  output logic [N_CH-1:0][15:0]     o_tb_temp,     // terminal temps
  output logic [N_CJC-1:0][31:0]    o_cjc_val,     // reported cjc
  output logic [N_CH-1:0][23:0]     o_tc_corr      // thermo correction
);
  localparam int NT = N_CH + N_CJC;
  localparam int NB = NT * N_COND;

  typedef logic [NT-1:0][N_COND-1:0] cacjc_mat_t;

  typedef struct packed {
    cacjc_mat_t                diag_en;
    cacjc_mat_t                flt_en;
    cacjc_mat_t                irq_en;
    cacjc_mat_t                alm_prev;
    cacjc_mat_t                irq_diag;
    cacjc_mat_t                flt_pend;
    cacjc_mat_t                irq_pend;
    cacjc_mat_t                diag;
    cacjc_scan_t               scan;
    logic                      fmt_flt;
    logic                      units_f;
    logic signed [15:0]        offset;
    logic [N_CH-1:0][2:0]      tc_type;
    logic                      flt_valid;
    logic [3:0]                flt_ch;
    logic [3:0]                flt_cond;
    logic                      irq_valid;
    logic [4:0]                irq_word;
    logic [N_CH-1:0][15:0]     tb_temp;
    logic [N_CJC-1:0][31:0]    cjc_val;
    logic [N_CH-1:0][23:0]     tc_corr;
    logic [31:0]               prdata;
    logic                      pslverr;
  } cacjc_st_t;

  cacjc_st_t q;
  cacjc_st_t d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [6:0] first_set(input logic [NB-1:0] v);
    logic [6:0] idx;
    idx = 7'h00;
    for (int b = NB - 1; b >= 0; b--) begin
      if (v[b]) begin
        idx = 7'(b);
      end
    end
    return idx;
  endfunction

  function automatic logic [7:0] ch_mult(input int ch);
    logic [7:0] m;
    case (ch)
      0:       m = `CACJC_MUL_CH1;
      1:       m = `CACJC_MUL_CH2;
      2:       m = `CACJC_MUL_CH3;
      3:       m = `CACJC_MUL_CH4;
      4:       m = `CACJC_MUL_CH5;
      5:       m = `CACJC_MUL_CH6;
      6:       m = `CACJC_MUL_CH7;
      default: m = `CACJC_MUL_CH8;
    endcase
    return m;
  endfunction

  function automatic logic [8:0] seebeck(input logic [2:0] t);
    logic [8:0] s;
    case (cacjc_tc_t'(t))
      CACJC_TC_J: s = `CACJC_SEEB_J;
      CACJC_TC_K: s = `CACJC_SEEB_K;
      CACJC_TC_T: s = `CACJC_SEEB_T;
      CACJC_TC_E: s = `CACJC_SEEB_E;
      CACJC_TC_N: s = `CACJC_SEEB_N;
      CACJC_TC_R: s = `CACJC_SEEB_R;
      CACJC_TC_S: s = `CACJC_SEEB_S;
      default:    s = `CACJC_SEEB_B;
    endcase
    return s;
  endfunction

  function automatic logic signed [15:0] sat16(
    input logic signed [16:0] v
  );
    logic signed [15:0] r;
    if (v > 17'sh07FFF) begin
      r = 16'sh7FFF;
    end else if (v < -17'sh08000) begin
      r = -16'sh8000;
    end else begin
      r = v[15:0];
    end
    return r;
  endfunction

  function automatic logic signed [15:0] clamp_ofs(
    input logic signed [15:0] v,
    input logic               units_f
  );
    logic signed [15:0] lim;
    logic signed [15:0] r;
    lim = units_f ? `CACJC_LIM_F : `CACJC_LIM_C;
    if (v > lim) begin
      r = lim;
    end else if (v < -lim) begin
      r = -lim;
    end else begin
      r = v;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // cold-junction values and terminal temperatures

  logic                     scan1;
  logic                     scan2;
  logic signed [15:0]       ref_t;
  logic [N_CJC-1:0][15:0]   cjc_t;
  logic [N_CJC-1:0][31:0]   cjc_f;
  logic signed [15:0]       t_a;
  logic signed [15:0]       t_b;
  logic signed [23:0]       diff;

  always_comb begin
    scan1 = (q.scan == CACJC_SCAN_BOTH) ||
            (q.scan == CACJC_SCAN_FIRST);
    scan2 = (q.scan == CACJC_SCAN_BOTH) ||
            (q.scan == CACJC_SCAN_SECND);
    ref_t = q.units_f ? `CACJC_REF_F : `CACJC_REF_C;
    for (int s = 0; s < N_CJC; s++) begin
      cjc_t[s] = sat16(17'(signed'(i_cjc_temp[s])) +
                       17'(q.offset));
    end
    if (scan1) begin
      t_a = cjc_t[0];
    end else if (scan2) begin
      t_a = cjc_t[1];
    end else begin
      t_a = ref_t;
    end
    t_b  = scan2 ? signed'(cjc_t[1]) : t_a;
    diff = 24'(t_a) - 24'(t_b);
  end

  assign o_cjc_conv = {scan2, scan1};

  for (genvar s = 0; s < N_CJC; s++) begin : g_flt
    cacjc_i2f #(
      .FRAC (FRAC)
    ) u_i2f (
      .i_val (cjc_t[s]),
      .o_flt (cjc_f[s])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic              setup;
  logic              access;
  logic [11:0]       a;
  logic [11:0]       rel;
  logic [3:0]        ri;
  cacjc_mat_t        rise;
  cacjc_mat_t        new_flt;
  cacjc_mat_t        new_irq;
  cacjc_mat_t        flt_pop;
  cacjc_mat_t        irq_pop;
  logic [6:0]        fi;
  logic [6:0]        ii;
  logic [N_COND-1:0] cmask;
  logic signed [23:0] tb;
  logic [31:0]       rd;
  logic              hit;
  logic              wr_ok;

  always_comb begin
    d       = q;
    setup   = i_psel && !i_penable;
    access  = i_psel && i_penable;
    a       = {i_paddr[11:2], 2'b00};
    rel     = 12'h000;
    ri      = 4'h0;
    rd      = 32'h00000000;
    hit     = 1'b1;
    wr_ok   = 1'b0;
    cmask   = {N_COND{1'b1}};
    flt_pop = '0;
    irq_pop = '0;
    tb      = 24'sh000000;

    // alarm occurrences and routing
    rise       = i_alarm & ~q.alm_prev;
    d.alm_prev = i_alarm;
    new_flt    = rise & q.flt_en;
    new_irq    = rise & q.irq_en;
    d.irq_diag = (q.irq_diag & {NB{~i_host_scan}}) |
                 (new_irq & ~q.diag_en);
    d.diag     = (i_alarm & q.diag_en) | q.irq_diag;

    // fault log entries, one per occurrence
    fi = first_set(q.flt_pend);
    if (!q.flt_valid || i_flt_ready) begin
      d.flt_valid = |q.flt_pend;
      if (|q.flt_pend) begin
        flt_pop[fi / N_COND][fi % N_COND] = 1'b1;
        d.flt_ch   = 4'(fi / N_COND);
        d.flt_cond = 4'(fi % N_COND);
      end
    end
    d.flt_pend = (q.flt_pend & ~flt_pop) | new_flt;

    // interrupt requests identified by channel base word
    ii = first_set(q.irq_pend);
    if (!q.irq_valid || i_irq_ready) begin
      d.irq_valid = |q.irq_pend;
      if (|q.irq_pend) begin
        irq_pop[ii / N_COND][ii % N_COND] = 1'b1;
        d.irq_word = 5'(2 * (ii / N_COND));
      end
    end
    d.irq_pend = (q.irq_pend & ~irq_pop) | new_irq;

    // compensation per channel
    for (int c = 0; c < N_CH; c++) begin
      tb = 24'(t_a) - (diff * signed'(24'(ch_mult(c)))) /
           `CACJC_MUL_DIV;
      d.tb_temp[c] = tb[15:0];
      d.tc_corr[c] = 24'(signed'(tb[15:0])) *
                     signed'(24'(seebeck(q.tc_type[c])));
    end
    for (int s = 0; s < N_CJC; s++) begin
      d.cjc_val[s] = q.fmt_flt ? cjc_f[s] :
                     {{16{cjc_t[s][15]}}, cjc_t[s]};
    end

    // register decode
    if (a < `CACJC_OFS_CFG) begin
      rel   = a - `CACJC_OFS_ENA;
      ri    = rel[5:2];
      rd    = {2'b00, q.irq_en[ri], q.flt_en[ri], q.diag_en[ri]};
      wr_ok = 1'b1;
      if (ri >= 4'(N_CH)) begin
        cmask = `CACJC_CJC_COND_MASK;
      end
    end else if (a == `CACJC_OFS_CFG) begin
      rd = {q.offset, 12'h000, q.units_f, q.fmt_flt, q.scan};
      wr_ok = 1'b1;
    end else if (a == `CACJC_OFS_TCTYPE) begin
      rd    = 32'(q.tc_type);
      wr_ok = 1'b1;
    end else if (a < `CACJC_OFS_CJCVAL) begin
      rel = a - `CACJC_OFS_TBTEMP;
      rd  = {{16{q.tb_temp[rel[4:2]][15]}}, q.tb_temp[rel[4:2]]};
    end else if (a < `CACJC_OFS_DIAG) begin
      rel = a - `CACJC_OFS_CJCVAL;
      rd  = q.cjc_val[rel[2]];
    end else if (a < `CACJC_OFS_TCCORR) begin
      rel = a - `CACJC_OFS_DIAG;
      ri  = rel[5:2];
      if (ri < 4'(NT)) begin
        rd = 32'(q.diag[ri]);
      end else begin
        hit = 1'b0;
      end
    end else if (a < `CACJC_OFS_END) begin
      rel = a - `CACJC_OFS_TCCORR;
      rd  = {{8{q.tc_corr[rel[4:2]][23]}}, q.tc_corr[rel[4:2]]};
    end else begin
      hit = 1'b0;
    end

    if (setup) begin
      d.prdata  = i_pwrite ? 32'h00000000 : rd;
      d.pslverr = !hit || (i_pwrite && !wr_ok);
    end

    // write takes effect at the access edge
    if (access && i_pwrite && !q.pslverr) begin
      if (a < `CACJC_OFS_CFG) begin
        d.diag_en[ri] = i_pwdata[`CACJC_ENA_DIAG_LSB +: N_COND] & cmask;
        d.flt_en[ri]  = i_pwdata[`CACJC_ENA_FLT_LSB +: N_COND] & cmask;
        d.irq_en[ri]  = i_pwdata[`CACJC_ENA_IRQ_LSB +: N_COND] & cmask;
      end else if (a == `CACJC_OFS_CFG) begin
        d.scan    = cacjc_scan_t'(i_pwdata[`CACJC_CFG_SCAN_LSB +: 2]);
        d.fmt_flt = i_pwdata[`CACJC_CFG_FMT_BIT];
        d.units_f = i_pwdata[`CACJC_CFG_UNIT_BIT];
        d.offset  = clamp_ofs(i_pwdata[`CACJC_CFG_OFS_LSB +: 16],
                              i_pwdata[`CACJC_CFG_UNIT_BIT]);
      end else if (a == `CACJC_OFS_TCTYPE) begin
        d.tc_type = i_pwdata[3*N_CH-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q         <= '0;
      q.diag_en <= {NT{`CACJC_RST_ENA}};
      q.flt_en  <= {NT{`CACJC_RST_ENA}};
      q.irq_en  <= {NT{`CACJC_RST_ENA}};
      q.scan    <= CACJC_SCAN_NONE;
      q.offset  <= `CACJC_RST_OFFSET;
      q.tc_type <= {N_CH{`CACJC_RST_TCTYPE}};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_pready    = 1'b1;
  assign o_prdata    = q.prdata;
  assign o_pslverr   = q.pslverr;
  assign o_diag      = q.diag;
  assign o_flt_valid = q.flt_valid;
  assign o_flt_ch    = q.flt_ch;
  assign o_flt_cond  = q.flt_cond;
  assign o_irq_valid = q.irq_valid;
  assign o_irq_word  = q.irq_word;
  assign o_tb_temp   = q.tb_temp;
  assign o_cjc_val   = q.cjc_val;
  assign o_tc_corr   = q.tc_corr;
endmodule

/* File: tb/cacjc_checker.sv */
`timescale 1ns/1ps
`include "cacjc_defines.svh"
module cacjc_checker import cacjc_pkg::*; #(
  parameter int N_CH   = 8,
  parameter int N_CJC  = 2,
  parameter int N_COND = 10
) (
  input wire logic                              i_core_clk,  // clock
  input wire logic                              i_rst_b,     // reset, low
  input wire logic                              i_psel,      // apb select
  input wire logic                              i_penable,   // apb enable
  input wire logic                              i_pwrite,    // apb write
  input wire logic [11:0]                       i_paddr,     // apb address
  input wire logic [31:0]                       i_pwdata,    // apb data
  input wire logic [N_CH+N_CJC-1:0][N_COND-1:0] i_alarm,     // alarms
  input wire logic                              i_flt_ready, // fault taken
  input wire logic                              i_irq_ready, // irq taken
  input wire logic [N_CJC-1:0]                  o_cjc_conv,  // convert
  input wire logic [N_CH+N_CJC-1:0][N_COND-1:0] o_diag,      // diag bits
  input wire logic                              o_flt_valid, // fault valid
  input wire logic [3:0]                        o_flt_ch,    // fault chan
  input wire logic [3:0]                        o_flt_cond,  // fault cond
  input wire logic                              o_irq_valid, // irq valid
  input wire logic [4:0]                        o_irq_word,  // irq word
  input wire logic [N_CJC-1:0][31:0]            o_cjc_val    // cjc values
);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of scan and format fields, taken at the access edge
  logic [2:0] cfg_q;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q <= 3'h0;
    end else if (i_psel && i_penable && i_pwrite &&
                 i_paddr[11:2] == 10'h00A) begin
      cfg_q <= i_pwdata[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_flt_wait;
    o_flt_valid && !i_flt_ready;
  endsequence
  sequence s_irq_wait;
    o_irq_valid && !i_irq_ready;
  endsequence

  property p_diag_cause;
    (o_diag & ~$past(o_diag) & ~$past(i_alarm) & ~$past(i_alarm, 2)) == '0;
  endproperty
  property p_cjc_diag;
    ((o_diag[N_CH] | o_diag[N_CH+1]) & ~`CACJC_CJC_COND_MASK) == '0;
  endproperty
  property p_flt_hold;
    s_flt_wait |=> o_flt_valid && $stable(o_flt_ch) && $stable(o_flt_cond);
  endproperty
  property p_irq_hold;
    s_irq_wait |=> o_irq_valid && $stable(o_irq_word);
  endproperty
  property p_irq_word;
    o_irq_valid |-> !o_irq_word[0] && o_irq_word <= 5'd18;
  endproperty
  property p_flt_code;
    o_flt_valid |-> o_flt_ch <= 4'd9 && o_flt_cond <= 4'd9 &&
      (o_flt_ch < 4'd8 || o_flt_cond inside {4'd2, 4'd3, 4'd4});
  endproperty
  property p_scan_conv;
    $stable(cfg_q[1:0]) |-> o_cjc_conv ==
      {cfg_q[1:0] == 2'h1 || cfg_q[1:0] == 2'h3,
       cfg_q[1:0] == 2'h1 || cfg_q[1:0] == 2'h2};
  endproperty
  property p_int_sign;
    $stable(cfg_q[2]) && !cfg_q[2] |->
      o_cjc_val[0][31:16] == {16{o_cjc_val[0][15]}} &&
      o_cjc_val[1][31:16] == {16{o_cjc_val[1][15]}};
  endproperty

  a_diag_cause: assert property (p_diag_cause)
    else $error("diag bit set without alarm");
  a_cjc_diag: assert property (p_cjc_diag)
    else $error("cjc diag outside under over open");
  a_flt_hold: assert property (p_flt_hold)
    else $error("fault entry dropped before taken");
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped before taken");
  a_irq_word: assert property (p_irq_word)
    else $error("irq word not a channel base");
  a_flt_code: assert property (p_flt_code)
    else $error("fault entry code out of range");
  a_scan_conv: assert property (p_scan_conv)
    else $error("sensor conversion does not follow scan mode");
  a_int_sign: assert property (p_int_sign)
    else $error("upper word not sign extension");
endmodule

bind cacjc_top cacjc_checker #(.N_CH(N_CH), .N_CJC(N_CJC), .N_COND(N_COND))
  u_chk (.i_core_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .i_alarm, .i_flt_ready, .i_irq_ready, .o_cjc_conv, .o_diag,
    .o_flt_valid, .o_flt_ch, .o_flt_cond, .o_irq_valid, .o_irq_word,
    .o_cjc_val);

/* File: tb/cacjc_host.sv */
`timescale 1ns/1ps
module cacjc_host (
  input  wire logic i_core_clk,  // clock
  input  wire logic i_rst_b,     // reset, low
  input  wire logic i_slow,      // take entries only now and then
  output logic      o_scan,      // input scan pulse
  output logic      o_flt_ready, // fault entry taken
  output logic      o_irq_ready  // interrupt taken
);
  logic [1:0] cnt_q;
  initial o_scan = 1'b0;
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 2'h0;
      o_flt_ready <= 1'b0;
      o_irq_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      o_flt_ready <= !i_slow || cnt_q == 2'h0;
      o_irq_ready <= !i_slow || cnt_q == 2'h2;
    end
  end
  task pulse_scan;
    @(posedge i_core_clk);
    o_scan <= 1'b1;
    @(posedge i_core_clk);
    o_scan <= 1'b0;
  endtask
endmodule

/* File: tb/tb_channel_alarm_and_cold_junction_comp.sv */
`timescale 1ns/1ps
module tb_channel_alarm_and_cold_junction_comp;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [9:0][9:0] alarm = '0;
  logic [1:0][15:0] cjc_t = '0;
  logic pready, pslverr, fv, iv, scan, frdy, irdy;
  logic [31:0] prdata;
  logic [1:0] conv;
  logic [9:0][9:0] diag;
  logic [3:0] fch, fcond;
  logic [4:0] iw;
  logic [7:0][15:0] tbt;
  logic [1:0][31:0] cval;
  logic [7:0][23:0] corr;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int q_f[$], q_i[$], ef[$], ei[$];
  int mul[8] = '{10, 5, 25, 25, 45, 60, 75, 90};
  int slope[8] = '{52, 41, 43, 61, 27, 6, 6, 1};

  always #2.5 clk = ~clk;

  cacjc_top dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_alarm(alarm), .i_host_scan(scan), .i_cjc_temp(cjc_t),
    .o_cjc_conv(conv), .o_diag(diag), .o_flt_valid(fv), .o_flt_ch(fch),
    .o_flt_cond(fcond), .i_flt_ready(frdy), .o_irq_valid(iv),
    .o_irq_word(iw), .i_irq_ready(irdy), .o_tb_temp(tbt),
    .o_cjc_val(cval), .o_tc_corr(corr));
  cacjc_host host (.i_core_clk(clk), .i_rst_b(rst_b), .i_slow(slow),
    .o_scan(scan), .o_flt_ready(frdy), .o_irq_ready(irdy));
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (fv && frdy) q_f.push_back(fch * 10 + fcond);
    if (iv && irdy) q_i.push_back(iw);
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task wrap_up;
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task apb(input bit w, input int a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a[11:0];
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic int msk(input int k);
    return k > 7 ? 'h1C : 'h3FF;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int den[10], fen[10], ien[10], ty[8];
    int a, b, off, t;
    logic [31:0] r, tcw;
    logic e;
    void'($urandom(51));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    // defaults, refusals, everything off
    for (int k = 0; k < 12; k++) begin
      apb(0, 4 * k, 0, r, e);
      chk(r, 0, "reset value");
    end
    apb(0, 'hA0, 0, r, e);
    chk(32'(e), 1, "unmapped");
    apb(1, 'h30, 32'h1234, r, e);
    chk(32'(e), 1, "read-only write");
    alarm <= '1;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 10; k++) chk(32'(diag[k]), 0, "diag off");
    chk(32'({fv, iv}), 0, "events off");
    alarm <= '0;
    // diagnostic enables in random mixes
    repeat (4) begin
      for (int k = 0; k < 10; k++) begin
        den[k] = $urandom % 1024;
        apb(1, 4 * k, den[k], r, e);
        alarm[k] <= 10'($urandom);
      end
      repeat (3) @(posedge clk);
      for (int k = 0; k < 10; k++)
        chk(32'(diag[k]), 32'(alarm[k]) & den[k] & msk(k), "diag");
    end
    alarm <= '0;
    // fault and interrupt entries with a stalling host
    slow <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      fen[k] = $urandom % 1024 & msk(k);
      ien[k] = $urandom % 1024 & msk(k);
      apb(1, 4 * k, (ien[k] << 20) | (fen[k] << 10), r, e);
    end
    repeat (2) begin
      q_f.delete();
      q_i.delete();
      ef.delete();
      ei.delete();
      for (int k = 0; k < 10; k++) alarm[k] <= 10'($urandom);
      @(posedge clk);
      for (int k = 0; k < 10; k++)
        for (int c = 0; c < 10; c++)
          if (alarm[k][c]) begin
            if (fen[k][c]) ef.push_back(k * 10 + c);
            if (ien[k][c]) ei.push_back(2 * k);
          end
      while (q_f.size() < ef.size() || q_i.size() < ei.size())
        @(posedge clk);
      repeat (10) @(posedge clk);
      chk(q_f.size(), ef.size(), "fault count");
      foreach (ef[i]) chk(q_f[i], ef[i], "fault entry");
      chk(q_i.size(), ei.size(), "irq count");
      foreach (ei[i]) chk(q_i[i], ei[i], "irq word");
      alarm <= '0;
      repeat (5) @(posedge clk);
    end
    slow <= 1'b0;
    host.pulse_scan();
    // interrupt with diagnostics off
    for (int k = 0; k < 10; k++) apb(1, 4 * k, k == 1 ? 1 << 21 : 0, r, e);
    q_i.delete();
    alarm[1][1] <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(diag[1]), 2, "irq diag set");
    alarm[1][1] <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(diag[1]), 2, "irq diag held");
    chk(q_i.size() == 1 ? q_i[0] : -1, 2, "irq base word");
    host.pulse_scan();
    repeat (3) @(posedge clk);
    chk(32'(diag[1]), 0, "scan clears");
    // compensation in every scan mode
    tcw = '0;
    for (int k = 0; k < 8; k++) begin
      ty[k] = $urandom % 8;
      tcw[3 * k +: 3] = 3'(ty[k]);
    end
    apb(1, 'h2C, tcw, r, e);
    for (int s = 0; s < 4; s++) begin
      a = int'($urandom % 1600) - 800;
      b = int'($urandom % 1600) - 800;
      off = s > 0 ? int'($urandom % 801) - 400 : 0;
      cjc_t[0] <= a[15:0];
      cjc_t[1] <= b[15:0];
      apb(1, 'h28, {off[15:0], 14'h0, 2'(s)}, r, e);
      repeat (3) @(posedge clk);
      chk(32'(conv), s == 0 ? 0 : s == 1 ? 3 : s == 2 ? 1 : 2, "conv");
      for (int k = 0; k < 8; k++) begin
        case (s)
          0: t = 400;
          1: t = a + off - (a - b) * mul[k] / 100;
          2: t = a + off;
          default: t = b + off;
        endcase
        chk(32'(tbt[k]), 32'(t[15:0]), "terminal temp");
        t = t * slope[ty[k]];
        chk(32'(corr[k]), 32'(t[23:0]), "correction");
      end
      if (s == 1) begin
        chk(cval[0], a + off, "cjc first");
        chk(cval[1], b + off, "cjc second");
      end
    end
    cjc_t[0] <= 16'h01E0;
    cjc_t[1] <= 16'hFFA8;
    apb(1, 'h28, 32'h0000_0005, r, e);
    repeat (3) @(posedge clk);
    chk(cval[0], 32'h41F0_0000, "float pos");
    chk(cval[1], 32'hC0B0_0000, "float neg");
    apb(1, 'h28, 32'h7FFF_0008, r, e);
    apb(0, 'h28, 0, r, e);
    chk(32'(r[31:16]), 32'h02D0, "offset limit F");
    apb(1, 'h28, 32'h8000_0000, r, e);
    apb(0, 'h28, 0, r, e);
    chk(32'(r[31:16]), 32'hFE70, "offset limit C");
    wrap_up();
  end
endmodule
